// >>> core/mar_regs.vh
// Constants for the monitor output and alarm relay block.
// Assumes a single 50 MHz clock and a plain address/strobe register port.
`ifndef MAR_REGS_VH
`define MAR_REGS_VH

// Register byte offsets.
`define MAR_OFF_AM_GAIN 8'h00
`define MAR_OFF_AM_ITEM 8'h04
`define MAR_OFF_PM_RATE 8'h08
`define MAR_OFF_PM_AVG 8'h0c
`define MAR_OFF_PM_ITEM 8'h10
`define MAR_OFF_RLY_MODE 8'h14
`define MAR_OFF_COMM_AO 8'h18
`define MAR_OFF_STATUS 8'h1c

// Reset values.
`define MAR_RST_AM_GAIN 8'h64
`define MAR_RST_AM_ITEM 4'h0
`define MAR_RST_PM_RATE 13'h05dc
`define MAR_RST_PM_AVG 8'h00
`define MAR_RST_PM_ITEM 4'h0
`define MAR_RST_RLY_MODE 1'b0
`define MAR_RST_COMM_AO 12'h000

// Setting limits.
`define MAR_ITEM_MAX 4'ha
`define MAR_PCT_MAX 8'hc8
`define MAR_RATE_MIN 13'h012c
`define MAR_RATE_MAX 13'h1770

// Monitor items.
`define MAR_IT_FREQ1 4'h0
`define MAR_IT_FREQ2 4'h1
`define MAR_IT_CURR 4'h2
`define MAR_IT_VOLT 4'h3
`define MAR_IT_TORQ 4'h4
`define MAR_IT_LOAD 4'h5
`define MAR_IT_POWER 4'h6
`define MAR_IT_PID 4'h7
`define MAR_IT_PG 4'h8
`define MAR_IT_DCLINK 4'h9
`define MAR_IT_COMM 4'ha

// Full-scale volts per voltage class.
`define MAR_FS_VOUT_LO 17'h000fa
`define MAR_FS_VOUT_HI 17'h001f4
`define MAR_FS_DC_LO 17'h001f4
`define MAR_FS_DC_HI 17'h003e8

// Monitor amount: 4096 is 100 percent, 8191 is the ceiling.
`define MAR_AMT_SHIFT 12
`define MAR_AMT_CEIL 13'h1fff
`define MAR_DAC_MAX 12'hfff
`define MAR_PCT_DIV 21'h000064

// Pulse monitor timing.
`define MAR_FIXED_RATE 13'h0a6e
`define MAR_INC_K 15'h55e6
`define MAR_DUTY_K 13'h147b

// Clock and control voltage delay.
`define MAR_CLK_HZ 50000000
`define MAR_READY_MS 1000
`define MAR_READY_CYC (`MAR_READY_MS * (`MAR_CLK_HZ / 1000))

`endif

// >>> core/mar_scale.v
// Item selection and scaling of one monitor channel to a monitor amount.
// Assumes all quantities come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "mar_regs.vh"

module mar_scale (
  input wire clk,
  input wire rst_n,
  input wire [3:0] item,
  input wire [15:0] out_freq1,
  input wire [15:0] out_freq2,
  input wire [15:0] max_freq,
  input wire [15:0] out_current,
  input wire [15:0] inv_rated_current,
  input wire [15:0] out_voltage,
  input wire high_voltage_class,
  input wire [15:0] out_torque,
  input wire [15:0] motor_rated_torque,
  input wire [15:0] load_rate,
  input wire [15:0] motor_rated_load,
  input wire [15:0] power_in,
  input wire [15:0] inv_rated_power,
  input wire regen_active,
  input wire [15:0] pid_feedback,
  input wire [15:0] pid_full_scale,
  input wire [15:0] pg_feedback,
  input wire [15:0] sync_speed,
  input wire [15:0] dc_link_voltage,
  input wire [11:0] comm_value,
  output reg [12:0] amount_q
);
  reg [15:0] num;
  reg [16:0] fs;
  reg [27:0] quot;
  reg [12:0] amount_d;

  always @* begin
    num = 16'h0000;
    fs = 17'h00000;
    case (item)
      `MAR_IT_FREQ1: begin num = out_freq1; fs = {1'b0, max_freq}; end // RULE2
      `MAR_IT_FREQ2: begin num = out_freq2; fs = {1'b0, max_freq}; end // RULE2
      `MAR_IT_CURR: begin num = out_current; fs = {inv_rated_current, 1'b0}; end // RULE3
      `MAR_IT_VOLT: begin
        num = out_voltage;
        fs = high_voltage_class ? `MAR_FS_VOUT_HI : `MAR_FS_VOUT_LO;
      end
      `MAR_IT_TORQ: begin num = out_torque; fs = {motor_rated_torque, 1'b0}; end // RULE3
      `MAR_IT_LOAD: begin num = load_rate; fs = {motor_rated_load, 1'b0}; end // RULE3
      `MAR_IT_POWER: begin
        num = regen_active ? 16'h0000 : power_in; // RULE5
        fs = {inv_rated_power, 1'b0}; // RULE3
      end
      `MAR_IT_PID: begin num = pid_feedback; fs = {1'b0, pid_full_scale}; end
      `MAR_IT_PG: begin num = pg_feedback; fs = {1'b0, sync_speed}; end
      `MAR_IT_DCLINK: begin
        num = dc_link_voltage;
        fs = high_voltage_class ? `MAR_FS_DC_HI : `MAR_FS_DC_LO; // RULE4
      end
      default: begin
        num = 16'h0000;
        fs = 17'h00000;
      end
    endcase
    // A zero full scale would divide by zero, so the quotient reads zero.
    quot = (fs == 17'h00000) ? 28'h0000000 : ({num, 12'h000} / {11'h000, fs});
    if (item == `MAR_IT_COMM)
      amount_d = {1'b0, comm_value}; // RULE6
    else if (quot > {15'h0000, `MAR_AMT_CEIL})
      amount_d = `MAR_AMT_CEIL;
    else
      amount_d = quot[12:0];
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      amount_q <= 13'h0000;
    else
      amount_q <= amount_d;
  end
endmodule
`default_nettype wire

// >>> core/mar_pulse.v
// Pulse monitor generator: rate-modulated or duty-modulated pulse train.
// Assumes a 50 MHz clock; a 32-bit phase accumulator sets the pulse period.
`timescale 1ns/10ps
`default_nettype none
`include "mar_regs.vh"

module mar_pulse (
  input wire clk,
  input wire rst_n,
  input wire [12:0] amount,
  input wire [12:0] max_rate,
  input wire [7:0] avg_pct,
  output reg pulse_q
);
  reg [31:0] acc_q;
  wire [25:0] rate_prod;
  wire [13:0] rate_lin;
  wire [12:0] rate_var;
  wire [12:0] rate;
  wire [27:0] inc_prod;
  wire [33:0] thr_full;
  wire [32:0] thr;
  wire duty_mode;

  assign duty_mode = (avg_pct != 8'h00);
  assign rate_prod = max_rate * amount;
  assign rate_lin = rate_prod[25:12]; // RULE17
  assign rate_var = (rate_lin > {1'b0, max_rate}) ? max_rate : rate_lin[12:0]; // RULE10
  assign rate = duty_mode ? `MAR_FIXED_RATE : rate_var; // RULE11
  // Phase increment is rate times 2^32 over the clock rate, in 8 extra bits.
  assign inc_prod = rate * `MAR_INC_K;
  // High-time fraction is amount times setting over 4096 times 200.
  assign thr_full = amount * avg_pct * `MAR_DUTY_K;
  assign thr = (thr_full[33:32] != 2'b00) ? 33'h100000000 : {1'b0, thr_full[31:0]};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= 32'h00000000;
      pulse_q <= 1'b0;
    end else begin
      acc_q <= acc_q + {12'h000, inc_prod[27:8]};
      if (duty_mode)
        pulse_q <= ({1'b0, acc_q} < thr); // RULE12
      else
        pulse_q <= (rate != 13'h0000) && !acc_q[31]; // RULE10
    end
  end
endmodule
`default_nettype wire

// >>> core/mar_top.v
// Monitor outputs and alarm relay drive of the motor drive.
// Assumes quantities and the alarm come from drive logic on ref_clk.
// Settings arrive over a plain strobe port; read data follows a cycle later.
// The relay output is the coil drive; contact wiring lies outside.
// Notes on behaviour
// RULE1 - Analog item chosen by code 0 to 10
// RULE2 - Codes 0/1: frequency, full scale max frequency
// RULE3 - Current, torque, load, power: twice rated value
// RULE4 - DC link full scale 500 or 1000 V
// RULE5 - Power reads zero while regenerating
// RULE6 - Code 10 outputs communication-written 0-10 V value
// RULE7 - Analog gain 0 to 200 percent, 1 percent steps
// RULE8 - Pulse item uses the same code table
// RULE9 - Pulse rate setting 300 to 6000 per second
// RULE10 - Average 0%: rate varies, duty 50 percent
// RULE11 - Average 1-200%: fixed 2670 rate, duty varies
// RULE12 - Average voltage is 15.6 V times duty
// RULE13 - Mode 0: energize relay on alarm
// RULE14 - Mode 1: energize relay in normal operation
// RULE15 - Mode 1 energizes only after control voltage
// RULE16 - Relay released while unpowered or in reset
// RULE17 - Pulse rate linear with amount, max at 100%
`timescale 1ns/10ps
`default_nettype none
`include "mar_regs.vh"

module mar_top #(
  parameter [31:0] READY_CYC = `MAR_READY_CYC
) (
  input wire ref_clk,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire [15:0] out_freq1,
  input wire [15:0] out_freq2,
  input wire [15:0] max_freq,
  input wire [15:0] out_current,
  input wire [15:0] inv_rated_current,
  input wire [15:0] out_voltage,
  input wire high_voltage_class,
  input wire [15:0] out_torque,
  input wire [15:0] motor_rated_torque,
  input wire [15:0] load_rate,
  input wire [15:0] motor_rated_load,
  input wire [15:0] power_in,
  input wire [15:0] inv_rated_power,
  input wire regen_active,
  input wire [15:0] pid_feedback,
  input wire [15:0] pid_full_scale,
  input wire [15:0] pg_feedback,
  input wire [15:0] sync_speed,
  input wire [15:0] dc_link_voltage,
  input wire drive_alarm,
  output reg [11:0] analog_monitor_pin,
  output wire pulse_monitor_pin,
  output reg alarm_relay,
  output reg ctrl_voltage_ok
);
  reg rst_meta_q;
  reg rst_sync_q;
  wire rst_n_i;

  // Settings written by software.
  reg [7:0] analog_monitor_gain_q;
  reg [3:0] analog_monitor_item_select_q;
  reg [12:0] pulse_monitor_max_rate_q;
  reg [7:0] pulse_monitor_avg_voltage_q;
  reg [3:0] pulse_monitor_item_select_q;
  reg alarm_relay_polarity_mode_q;
  reg [11:0] comm_written_analog_value_q;

  // Relay timing and the monitor datapath.
  reg [31:0] ready_cnt_q;
  reg alarm_relay_d;
  wire [25:0] amt_bus;
  wire [12:0] analog_amount;
  wire [12:0] pulse_amount;
  wire [20:0] analog_prod;
  wire [20:0] analog_lvl;
  wire [11:0] analog_d;
  reg [31:0] rdata_d;

  // Decoded write checks, channel item codes and the status word.
  wire pct_wr_ok;
  wire item_wr_ok;
  wire rate_wr_ok;
  wire ready_hit;
  wire [3:0] chan_item [0:1];
  wire [31:0] status_word;

  // The reset is released through two flops so that all logic leaves reset together.
  // Only the second flop is read by any logic.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rst_n_i = rst_sync_q;

  // Both percent settings and both item codes share their limits,
  // so one check serves each pair.
  assign pct_wr_ok = (reg_wdata[31:8] == 24'h000000) && (reg_wdata[7:0] <= `MAR_PCT_MAX);
  assign item_wr_ok = (reg_wdata[31:4] == 28'h0000000) && (reg_wdata[3:0] <= `MAR_ITEM_MAX);
  assign rate_wr_ok = (reg_wdata[31:13] == 19'h00000) && (reg_wdata[12:0] >= `MAR_RATE_MIN) &&
                      (reg_wdata[12:0] <= `MAR_RATE_MAX);

  // Out-of-range percent, rate and item writes are ignored so that a setting never leaves its range.
  always @(posedge ref_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      analog_monitor_gain_q <= `MAR_RST_AM_GAIN;
      analog_monitor_item_select_q <= `MAR_RST_AM_ITEM;
      pulse_monitor_max_rate_q <= `MAR_RST_PM_RATE;
      pulse_monitor_avg_voltage_q <= `MAR_RST_PM_AVG;
      pulse_monitor_item_select_q <= `MAR_RST_PM_ITEM;
      alarm_relay_polarity_mode_q <= `MAR_RST_RLY_MODE;
      comm_written_analog_value_q <= `MAR_RST_COMM_AO;
    end else if (reg_wr) begin
      case (reg_addr)
        `MAR_OFF_AM_GAIN: begin
          if (pct_wr_ok)
            analog_monitor_gain_q <= reg_wdata[7:0]; // RULE7
        end
        `MAR_OFF_AM_ITEM: begin
          if (item_wr_ok)
            analog_monitor_item_select_q <= reg_wdata[3:0]; // RULE1
        end
        `MAR_OFF_PM_RATE: begin
          if (rate_wr_ok)
            pulse_monitor_max_rate_q <= reg_wdata[12:0]; // RULE9
        end
        `MAR_OFF_PM_AVG: begin
          if (pct_wr_ok)
            pulse_monitor_avg_voltage_q <= reg_wdata[7:0]; // RULE11
        end
        `MAR_OFF_PM_ITEM: begin
          if (item_wr_ok)
            pulse_monitor_item_select_q <= reg_wdata[3:0]; // RULE8
        end
        `MAR_OFF_RLY_MODE: begin
          // Only bit 0 is kept; upper bits are not checked.
          alarm_relay_polarity_mode_q <= reg_wdata[0];
        end
        `MAR_OFF_COMM_AO: begin
          // Taken as is; the pin follows two cycles later.
          comm_written_analog_value_q <= reg_wdata[11:0]; // RULE6
        end
        default: begin
        end
      endcase
    end
  end

  // Both channels share one scaler design and the same item table.
  // Two copies cost area but keep the channels independent.
  assign chan_item[0] = analog_monitor_item_select_q;
  assign chan_item[1] = pulse_monitor_item_select_q; // RULE8

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : chan
      mar_scale u_scale (
        .clk(ref_clk),
        .rst_n(rst_n_i),
        .item(chan_item[g]), // RULE8
        .out_freq1(out_freq1),
        .out_freq2(out_freq2),
        .max_freq(max_freq),
        .out_current(out_current),
        .inv_rated_current(inv_rated_current),
        .out_voltage(out_voltage),
        .high_voltage_class(high_voltage_class),
        .out_torque(out_torque),
        .motor_rated_torque(motor_rated_torque),
        .load_rate(load_rate),
        .motor_rated_load(motor_rated_load),
        .power_in(power_in),
        .inv_rated_power(inv_rated_power),
        .regen_active(regen_active),
        .pid_feedback(pid_feedback),
        .pid_full_scale(pid_full_scale),
        .pg_feedback(pg_feedback),
        .sync_speed(sync_speed),
        .dc_link_voltage(dc_link_voltage),
        .comm_value(comm_written_analog_value_q),
        .amount_q(amt_bus[g*13 +: 13])
      );
    end
  endgenerate
  // Channel 0 feeds the analog pin, channel 1 the pulses.
  assign analog_amount = amt_bus[12:0];
  assign pulse_amount = amt_bus[25:13];

  // Level is amount times gain percent; 4095 codes stand for 10 V and clip there.
  // Gain scales the written item too, so 100 percent passes it through.
  assign analog_prod = analog_amount * analog_monitor_gain_q;
  assign analog_lvl = analog_prod / `MAR_PCT_DIV; // RULE7
  assign analog_d = (analog_lvl > {9'h000, `MAR_DAC_MAX}) ? `MAR_DAC_MAX :
                    analog_lvl[11:0];

  always @(posedge ref_clk or negedge rst_n_i) begin
    if (!rst_n_i)
      analog_monitor_pin <= 12'h000;
    else
      analog_monitor_pin <= analog_d; // RULE1
  end

  // The pin is registered in the generator, so it has no decode glitches.
  // Both pulse modes share the one phase accumulator.
  mar_pulse u_pulse (
    .clk(ref_clk),
    .rst_n(rst_n_i),
    .amount(pulse_amount),
    .max_rate(pulse_monitor_max_rate_q),
    .avg_pct(pulse_monitor_avg_voltage_q),
    .pulse_q(pulse_monitor_pin)
  );

  assign ready_hit = (ready_cnt_q >= READY_CYC - 32'h00000001);

  // Control voltage counts as established a fixed delay after reset release.
  // The counter stops once the flag is set, so it can never wrap.
  always @(posedge ref_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ready_cnt_q <= 32'h00000000;
      ctrl_voltage_ok <= 1'b0;
    end else if (!ctrl_voltage_ok) begin
      ready_cnt_q <= ready_cnt_q + 32'h00000001;
      if (ready_hit)
        ctrl_voltage_ok <= 1'b1; // RULE15
    end
  end

  // Both polarities hold the coil released until control voltage is up.
  // A polarity write acts at the next edge and may make the relay chatter.
  always @* begin
    if (!ctrl_voltage_ok)
      alarm_relay_d = 1'b0; // RULE15
    else if (alarm_relay_polarity_mode_q)
      alarm_relay_d = !drive_alarm; // RULE14
    else
      alarm_relay_d = drive_alarm; // RULE13
  end

  // The coil drops out at once on reset, as it would with power removed.
  // It stays released until the internal reset has gone.
  always @(posedge ref_clk or negedge rst_n_i) begin
    if (!rst_n_i)
      alarm_relay <= 1'b0; // RULE16
    else
      alarm_relay <= alarm_relay_d;
  end

  // Status shows ready flag, relay and pulse pin live, plus the analog amount and only the top two analog pin bits.
  assign status_word = {14'h0000, ctrl_voltage_ok, alarm_relay,
                        pulse_monitor_pin, analog_amount[12:0],
                        analog_monitor_pin[11:10]};

  always @* begin
    rdata_d = 32'h00000000;
    case (reg_addr)
      `MAR_OFF_AM_GAIN:
        rdata_d = {24'h000000, analog_monitor_gain_q};
      `MAR_OFF_AM_ITEM:
        rdata_d = {28'h0000000, analog_monitor_item_select_q};
      `MAR_OFF_PM_RATE:
        rdata_d = {19'h00000, pulse_monitor_max_rate_q};
      `MAR_OFF_PM_AVG:
        rdata_d = {24'h000000, pulse_monitor_avg_voltage_q};
      `MAR_OFF_PM_ITEM:
        rdata_d = {28'h0000000, pulse_monitor_item_select_q};
      `MAR_OFF_RLY_MODE:
        rdata_d = {31'h00000000, alarm_relay_polarity_mode_q};
      `MAR_OFF_COMM_AO:
        rdata_d = {20'h00000, comm_written_analog_value_q};
      `MAR_OFF_STATUS:
        rdata_d = status_word;
      default:
        rdata_d = 32'h00000000;
    endcase
  end

  // Read data stands only in the cycle after the strobe and is zero otherwise.
  // Zero between reads keeps a stale word from looking fresh.
  always @(posedge ref_clk or negedge rst_n_i) begin
    if (!rst_n_i)
      reg_rdata <= 32'h00000000;
    else if (reg_rd)
      reg_rdata <= rdata_d;
    else
      reg_rdata <= 32'h00000000;
  end
endmodule
`default_nettype wire

// >>> testbench/mar_top_asserts.sv
// Checker of the monitor and relay block, bound to the top module.
// Assumes settings reach the top only over its plain strobe register port.
`timescale 1ns/10ps
`default_nettype none
`include "mar_regs.vh"

module mar_chk #(
  parameter [31:0] READY_CYC = 32'h14
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic regen_active,
  input wire logic drive_alarm,
  input wire logic [11:0] analog_monitor_pin,
  input wire logic alarm_relay,
  input wire logic ctrl_voltage_ok
);
  // Shadow settings rebuilt from accepted writes, since the checker sees no registers.
  logic [7:0] gain_q;
  logic [3:0] item_q;
  logic [11:0] comm_q;
  logic mode_q;
  logic [31:0] cnt_q;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gain_q <= `MAR_RST_AM_GAIN;
      item_q <= `MAR_RST_AM_ITEM;
      comm_q <= `MAR_RST_COMM_AO;
      mode_q <= `MAR_RST_RLY_MODE;
      cnt_q <= 32'h0;
    end else begin
      if (cnt_q < READY_CYC + 32'h8)
        cnt_q <= cnt_q + 32'h1;
      if (reg_wr && reg_addr == `MAR_OFF_AM_GAIN && reg_wdata <= 32'hc8)
        gain_q <= reg_wdata[7:0];
      if (reg_wr && reg_addr == `MAR_OFF_AM_ITEM && reg_wdata <= 32'ha)
        item_q <= reg_wdata[3:0];
      if (reg_wr && reg_addr == `MAR_OFF_COMM_AO)
        comm_q <= reg_wdata[11:0];
      if (reg_wr && reg_addr == `MAR_OFF_RLY_MODE)
        mode_q <= reg_wdata[0];
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  chk_relay_before_ok: assert property (!ctrl_voltage_ok |=> !alarm_relay)
    else $error("relay energized before control voltage");
  chk_relay_mode_zero: assert property (ctrl_voltage_ok && !mode_q |=> alarm_relay == $past(drive_alarm))
    else $error("relay does not follow alarm in mode 0");
  chk_relay_mode_one: assert property (ctrl_voltage_ok && mode_q |=> alarm_relay == !$past(drive_alarm))
    else $error("relay does not invert alarm in mode 1");
  chk_ok_held_low: assert property (cnt_q < READY_CYC |-> !ctrl_voltage_ok)
    else $error("control voltage flagged too early");
  chk_ok_in_time: assert property (cnt_q > READY_CYC + 32'h6 |-> ctrl_voltage_ok)
    else $error("control voltage flagged too late");
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data without a read");
  chk_gain_zero: assert property (gain_q == 8'h00 |=> analog_monitor_pin == 12'h000)
    else $error("analog output not zero at zero gain");
  chk_regen_zero: assert property ((item_q == 4'h6 && regen_active) [*4] |-> analog_monitor_pin == 12'h000)
    else $error("power item not zero while regenerating");
  chk_comm_value: assert property ((item_q == 4'ha && gain_q == 8'h64 && $stable(comm_q)) [*3]
    |-> analog_monitor_pin == comm_q)
    else $error("written analog value not output");
endmodule

bind mar_top mar_chk #(.READY_CYC(READY_CYC)) u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .regen_active(regen_active),
  .drive_alarm(drive_alarm), .analog_monitor_pin(analog_monitor_pin),
  .alarm_relay(alarm_relay), .ctrl_voltage_ok(ctrl_voltage_ok)
);
`default_nettype wire

// >>> testbench/mar_meter.sv
// Far-side model: pulse counter on the pulse pin and the relay contact wiring.
// Assumes the pulse pin changes only at ref_clk edges.
`timescale 1ns/10ps
`default_nettype none

module mar_meter (
  input wire logic ref_clk,
  input wire logic pulse_monitor_pin,
  input wire logic alarm_relay,
  output var int period_cyc,
  output var int high_cyc,
  output var int rise_cnt,
  output wire logic relay_open_contact,
  output wire logic relay_closed_contact
);
  int run_q = 0;
  int hi_q = 0;
  logic last_q = 1'b0;

  // A released coil closes the normally-closed pair, also with no power.
  assign relay_open_contact = alarm_relay;
  assign relay_closed_contact = !alarm_relay;

  initial begin
    period_cyc = 1;
    high_cyc = 0;
    rise_cnt = 0;
  end

  always @(posedge ref_clk) begin
    if (pulse_monitor_pin && !last_q) begin
      period_cyc <= run_q;
      high_cyc <= hi_q;
      rise_cnt <= rise_cnt + 1;
      run_q <= 1;
      hi_q <= 1;
    end else begin
      run_q <= run_q + 1;
      hi_q <= hi_q + int'(pulse_monitor_pin);
    end
    last_q <= pulse_monitor_pin;
  end
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
// Testbench for the monitor outputs and alarm relay block.
// Assumes the design, checker and meter model are compiled before it.
`timescale 1ns/10ps
`default_nettype none
`include "mar_regs.vh"

module tb_top;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic hv = 1'b0;
  logic regen = 1'b0;
  logic alarm = 1'b0;
  logic [15:0] fs = 16'h03e8;
  logic [15:0] rt = 16'h01f4;
  logic [15:0] qv [0:9] = '{default: 16'h0};
  wire [31:0] reg_rdata;
  wire [11:0] analog;
  wire pulse, relay, ok, co, cc;
  int period_cyc, high_cyc, rise_cnt;
  int fail_count = 0;
  int check_count = 0;
  logic [31:0] rd_v;
  logic [3:0] it;
  logic [7:0] g;
  logic h;
  logic [15:0] q;
  logic [11:0] ex;
  // Item, gain, voltage class, quantity, expected analog code.
  logic [40:0] rows [0:15] = '{
    {4'h0, 8'h64, 1'b0, 16'h00fa, 12'h400}, {4'h1, 8'hc8, 1'b0, 16'h00fa, 12'h800},
    {4'h2, 8'h64, 1'b0, 16'h01f4, 12'h800}, {4'h3, 8'h64, 1'b0, 16'h007d, 12'h800},
    {4'h3, 8'h64, 1'b1, 16'h007d, 12'h400}, {4'h4, 8'h64, 1'b0, 16'h00fa, 12'h400},
    {4'h5, 8'h64, 1'b0, 16'h02ee, 12'hc00}, {4'h6, 8'h64, 1'b0, 16'h01f4, 12'h800},
    {4'h7, 8'h64, 1'b0, 16'h01f4, 12'h800}, {4'h8, 8'h64, 1'b0, 16'h00fa, 12'h400},
    {4'h9, 8'h64, 1'b0, 16'h00fa, 12'h800}, {4'h9, 8'h64, 1'b1, 16'h00fa, 12'h400},
    {4'ha, 8'h64, 1'b0, 16'h0000, 12'h123}, {4'ha, 8'h00, 1'b0, 16'h0000, 12'h000},
    {4'h0, 8'hc8, 1'b0, 16'h03e8, 12'hfff}, {4'h0, 8'h32, 1'b0, 16'h01f4, 12'h400}};

  always #10 ref_clk = ~ref_clk;

  mar_top #(.READY_CYC(32'h14)) u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .out_freq1(qv[0]),
    .out_freq2(qv[1]), .max_freq(fs), .out_current(qv[2]), .inv_rated_current(rt),
    .out_voltage(qv[3]), .high_voltage_class(hv), .out_torque(qv[4]), .motor_rated_torque(rt),
    .load_rate(qv[5]), .motor_rated_load(rt), .power_in(qv[6]), .inv_rated_power(rt),
    .regen_active(regen), .pid_feedback(qv[7]), .pid_full_scale(fs), .pg_feedback(qv[8]),
    .sync_speed(fs), .dc_link_voltage(qv[9]), .drive_alarm(alarm), .analog_monitor_pin(analog),
    .pulse_monitor_pin(pulse), .alarm_relay(relay), .ctrl_voltage_ok(ok));

  mar_meter u_meter (.ref_clk(ref_clk), .pulse_monitor_pin(pulse), .alarm_relay(relay),
    .period_cyc(period_cyc), .high_cyc(high_cyc), .rise_cnt(rise_cnt),
    .relay_open_contact(co), .relay_closed_contact(cc));

  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_near(input int got, input int exp, input int tol);
    check_count++;
    if (got < exp - tol || got > exp + tol) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    rd_v = reg_rdata;
  endtask

  task automatic set_q(input int k, input logic [15:0] v);
    for (int j = 0; j < 10; j++) qv[j] <= (j == k) ? v : 16'h0;
  endtask

  // Waits for fresh pulse edges; a 40000-cycle loop bound covers a pin that never toggles.
  task automatic rises(input int n);
    int t;
    t = rise_cnt + n;
    for (int i = 0; i < 40000 && rise_cnt < t; i++) @(posedge ref_clk);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    #1900000;
    fail_count++;
    end_sim;
  end

  initial begin
    cyc(4);
    check_eq({30'h0, co, cc}, 32'h1);
    cyc(1);
    rst_n <= 1'b1;
    cyc(3);
    rd(`MAR_OFF_AM_GAIN);
    check_eq(rd_v, 32'h64);
    rd(8'h20);
    check_eq(rd_v, 32'h0);
    wr(`MAR_OFF_COMM_AO, 32'h123);
    for (int i = 0; i < 16; i++) begin
      {it, g, h, q, ex} = rows[i];
      wr(`MAR_OFF_AM_GAIN, {24'h0, g});
      wr(`MAR_OFF_AM_ITEM, {28'h0, it});
      hv <= h;
      set_q(int'(it), q);
      cyc(4);
      check_eq({20'h0, analog}, {20'h0, ex});
      $display("row %0d done", i);
    end
    wr(`MAR_OFF_AM_GAIN, 32'hc9);
    wr(`MAR_OFF_AM_ITEM, 32'h6);
    set_q(6, 16'h01f4);
    regen <= 1'b1;
    cyc(5);
    check_eq({20'h0, analog}, 32'h0);
    regen <= 1'b0;
    cyc(4);
    check_eq({20'h0, analog}, 32'h400);
    $display("regen test done");
    wr(`MAR_OFF_PM_ITEM, 32'h9);
    wr(`MAR_OFF_PM_RATE, 32'h1770);
    wr(`MAR_OFF_PM_RATE, 32'h012b);
    wr(`MAR_OFF_PM_RATE, 32'h1771);
    rd(`MAR_OFF_PM_RATE);
    check_eq(rd_v, 32'h1770);
    set_q(9, 16'h01f4);
    rises(2);
    check_near(period_cyc, 50000000 / 6000, 3);
    check_near(high_cyc, period_cyc / 2, 2);
    set_q(9, 16'h0177);
    rises(2);
    check_near(period_cyc, 50000000 / 4500, 3);
    set_q(9, 16'h01f4);
    wr(`MAR_OFF_PM_AVG, 32'h32);
    rises(2);
    check_near(period_cyc, 50000000 / 2670, 3);
    check_near(15600 * high_cyc / period_cyc, 3900, 10);
    $display("pulse test done");
    alarm <= 1'b1;
    cyc(2);
    rst_n <= 1'b0;
    cyc(2);
    check_eq({30'h0, co, cc}, 32'h1);
    alarm <= 1'b0;
    rst_n <= 1'b1;
    cyc(3);
    wr(`MAR_OFF_RLY_MODE, 32'h1);
    cyc(3);
    check_eq({30'h0, co, cc}, 32'h1);
    for (int i = 0; i < 40 && ok !== 1'b1; i++) @(posedge ref_clk);
    cyc(2);
    check_eq({30'h0, co, cc}, 32'h2);
    alarm <= 1'b1;
    cyc(2);
    check_eq({30'h0, co, cc}, 32'h1);
    wr(`MAR_OFF_RLY_MODE, 32'h0);
    cyc(2);
    check_eq({30'h0, co, cc}, 32'h2);
    alarm <= 1'b0;
    cyc(2);
    check_eq({30'h0, co, cc}, 32'h1);
    $display("relay test done");
    end_sim;
  end
endmodule
`default_nettype wire
